// *** core/gkd_pkg.sv ***
// package: constants, register map and carrier types of the ground key detector
package gkd_pkg;

    // timing: 1.25 ms debounce and filter step at a 5 ns clock
    localparam int unsigned CLK_PERIOD_PS  = 5000;
    localparam int unsigned STEP_PERIOD_US = 1250;
    localparam int unsigned STEP_CYCLES    = (STEP_PERIOD_US * 1000000) / CLK_PERIOD_PS;

    // register byte addresses
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] ADDR_LINEFEED     = 8'h00;
    localparam logic [7:0] ADDR_LOOP_RT_STAT = 8'h04;
    localparam logic [7:0] ADDR_IRQ_VEC_TWO  = 8'h08;
    localparam logic [7:0] ADDR_IRQ_EN_TWO   = 8'h0C;
    localparam logic [7:0] ADDR_GK_DBI       = 8'h10;
    localparam logic [7:0] ADDR_LONG_CUR     = 8'h14;
    localparam logic [7:0] ADDR_GK_EN_TH     = 8'h18;
    localparam logic [7:0] ADDR_GK_REL_TH    = 8'h1C;
    localparam logic [7:0] ADDR_GK_COEF      = 8'h20;
    localparam logic [7:0] ADDR_LOOP_OFFHK   = 8'h24;
    localparam logic [7:0] ADDR_LOOP_DBI     = 8'h28;

    // field positions (status and both interrupt registers share the layout)
    localparam int unsigned BIT_GK   = 0;
    localparam int unsigned BIT_LOOP = 1;
    localparam int unsigned NUM_DET  = 2;
    localparam int unsigned LF_W     = 3;

    // linefeed codes
    localparam logic [2:0] LF_FWD_ACTIVE = 3'h1;
    localparam logic [2:0] LF_TIP_OPEN   = 3'h3;
    localparam logic [2:0] LF_REV_ACTIVE = 3'h5;
    localparam logic [2:0] LF_RING_OPEN  = 3'h7;

    // filter
    localparam logic [15:0] COEF_MASK      = 16'hFFF8;
    localparam int unsigned COEF_FRAC_BITS = 14;

    // reset values
    localparam logic [15:0] RST_GK_COEF = 16'h0A10;
    localparam logic [15:0] RST_TH      = 16'h0000;
    localparam logic [15:0] RST_DBI     = 16'h0000;
    localparam logic [2:0]  RST_LF      = 3'h0;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // transistor currents from the monitor, signed
    typedef struct packed {
        logic signed [15:0] q1;
        logic signed [15:0] q2;
        logic signed [15:0] q5;
        logic signed [15:0] q6;
    } sense_t;

    // terminal ground indications
    typedef struct packed {
        logic tip_gnd;
        logic ring_gnd;
    } ground_t;

endpackage

// *** core/ground_key_detector.sv ***
// module: ground key detector with loop closure, linefeed shadow and axi4-lite registers
`timescale 1ns/10ps
module ground_key_detector
    import gkd_pkg::*;
#(
    parameter int unsigned STEP_CYC = STEP_CYCLES
)
(
    // clock and reset
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // axi4-lite write address
    input  wire logic                awvalid,
    output logic                     awready,
    input  wire logic [ADDR_W-1:0]   awaddr,
    // axi4-lite write data
    input  wire logic                wvalid,
    output logic                     wready,
    input  wire logic [31:0]         wdata,
    input  wire logic [3:0]          wstrb,
    // axi4-lite write response
    output logic                     bvalid,
    input  wire logic                bready,
    output logic [1:0]               bresp,
    // axi4-lite read address
    input  wire logic                arvalid,
    output logic                     arready,
    input  wire logic [ADDR_W-1:0]   araddr,
    // axi4-lite read data
    output logic                     rvalid,
    input  wire logic                rready,
    output logic [31:0]              rdata,
    output logic [1:0]               rresp,
    // line measurements
    input  wire sense_t              sense,
    input  wire logic signed [15:0]  loop_current,
    input  wire ground_t             ground,
    // linefeed drive and interrupt
    output logic [LF_W-1:0]          linefeed_state,
    output logic                     irq
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic                     awready_ff;
    logic                     wready_ff;
    logic                     bvalid_ff;
    logic [1:0]               bresp_ff;
    logic                     arready_ff;
    logic                     rvalid_ff;
    logic [31:0]              rdata_ff;
    logic [1:0]               rresp_ff;
    logic [ADDR_W-1:0]        waddr_ff;
    logic [31:0]              wdata_ff;
    logic [3:0]               wstrb_ff;
    logic                     wr_go;
    logic                     wr_hit;

    logic [LF_W-1:0]          shadow_ff;
    logic [NUM_DET-1:0]       irq_vec_ff;
    logic [NUM_DET-1:0]       irq_en_ff;
    logic                     irq_ff;
    logic [15:0]              gk_dbi_ff;
    logic [15:0]              gk_en_th_ff;
    logic [15:0]              gk_rel_th_ff;
    logic [15:0]              gk_coef_ff;
    logic [15:0]              loop_offhk_ff;
    logic [15:0]              loop_dbi_ff;

    logic [17:0]              step_cnt_ff;
    logic                     step_ff;

    logic                     open_state;
    logic signed [17:0]       long_sum;
    logic signed [15:0]       long_cur_ff;
    logic signed [15:0]       filt_ff;
    logic signed [33:0]       filt_delta;
    logic [16:0]              filt_mag;
    logic [16:0]              loop_mag;
    logic                     gk_cmp_ff;

    logic [NUM_DET-1:0]       det_in;
    logic [NUM_DET-1:0]       det_gate;
    logic [15:0]              det_ivl   [NUM_DET];
    logic [15:0]              det_cnt_ff [NUM_DET];
    logic                     det_ff    [NUM_DET];
    logic                     det_q_ff  [NUM_DET];
    logic [NUM_DET-1:0]       det_chg;
    logic                     loop_rise;

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite write side: address and data taken in either order

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= RESP_OKAY;
            waddr_ff   <= '0;
            wdata_ff   <= '0;
            wstrb_ff   <= '0;
        end
        else
        begin
            if (awvalid && awready_ff)
            begin
                awready_ff <= 1'b0;
                waddr_ff   <= awaddr;
            end
            if (wvalid && wready_ff)
            begin
                wready_ff <= 1'b0;
                wdata_ff  <= wdata;
                wstrb_ff  <= wstrb;
            end
            if (wr_go)
            begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_ff && bready)
            begin
                bvalid_ff  <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff  <= 1'b1;
            end
        end
    end

    assign wr_go = !awready_ff && !wready_ff && !bvalid_ff;

    always_comb
    begin
        case (waddr_ff)
            ADDR_LINEFEED, ADDR_IRQ_VEC_TWO, ADDR_IRQ_EN_TWO, ADDR_GK_DBI,
            ADDR_GK_EN_TH, ADDR_GK_REL_TH, ADDR_GK_COEF, ADDR_LOOP_OFFHK,
            ADDR_LOOP_DBI:
                wr_hit = 1'b1;
            // read-only words answer okay and ignore the data
            ADDR_LOOP_RT_STAT, ADDR_LONG_CUR:
                wr_hit = 1'b1;
            default:
                wr_hit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // software-written configuration

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_en_ff     <= '0;
            gk_dbi_ff     <= RST_DBI;
            gk_en_th_ff   <= RST_TH;
            gk_rel_th_ff  <= RST_TH;
            gk_coef_ff    <= RST_GK_COEF;
            loop_offhk_ff <= RST_TH;
            loop_dbi_ff   <= RST_DBI;
        end
        else if (wr_go)
        begin
            case (waddr_ff)
                ADDR_IRQ_EN_TWO:
                    if (wstrb_ff[0]) irq_en_ff <= wdata_ff[NUM_DET-1:0];
                ADDR_GK_DBI:
                begin
                    if (wstrb_ff[0]) gk_dbi_ff[7:0]  <= wdata_ff[7:0];
                    if (wstrb_ff[1]) gk_dbi_ff[15:8] <= wdata_ff[15:8];
                end
                ADDR_GK_EN_TH:
                begin
                    if (wstrb_ff[0]) gk_en_th_ff[7:0]  <= wdata_ff[7:0];
                    if (wstrb_ff[1]) gk_en_th_ff[15:8] <= wdata_ff[15:8];
                end
                ADDR_GK_REL_TH:
                begin
                    if (wstrb_ff[0]) gk_rel_th_ff[7:0]  <= wdata_ff[7:0];
                    if (wstrb_ff[1]) gk_rel_th_ff[15:8] <= wdata_ff[15:8];
                end
                ADDR_GK_COEF:
                begin
                    if (wstrb_ff[0]) gk_coef_ff[7:0]  <= wdata_ff[7:0] & COEF_MASK[7:0];
                    if (wstrb_ff[1]) gk_coef_ff[15:8] <= wdata_ff[15:8];
                end
                ADDR_LOOP_OFFHK:
                begin
                    if (wstrb_ff[0]) loop_offhk_ff[7:0]  <= wdata_ff[7:0];
                    if (wstrb_ff[1]) loop_offhk_ff[15:8] <= wdata_ff[15:8];
                end
                ADDR_LOOP_DBI:
                begin
                    if (wstrb_ff[0]) loop_dbi_ff[7:0]  <= wdata_ff[7:0];
                    if (wstrb_ff[1]) loop_dbi_ff[15:8] <= wdata_ff[15:8];
                end
                default:
                begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // linefeed shadow: software sets it, loop closure moves it to active

    assign loop_rise = det_chg[BIT_LOOP] && det_ff[BIT_LOOP];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            shadow_ff <= RST_LF;
        else if (wr_go && waddr_ff == ADDR_LINEFEED && wstrb_ff[0])
            shadow_ff <= wdata_ff[LF_W-1:0];
        else if (loop_rise && shadow_ff == LF_TIP_OPEN && ground.ring_gnd)
            shadow_ff <= LF_FWD_ACTIVE;
        else if (loop_rise && shadow_ff == LF_RING_OPEN && ground.tip_gnd)
            shadow_ff <= LF_REV_ACTIVE;
    end

    assign open_state = (shadow_ff == LF_TIP_OPEN) || (shadow_ff == LF_RING_OPEN);

    ////////////////////////////////////////////////////////////////////////////
    // 1.25 ms step enable for the filter and both debouncers

    always_ff @(posedge aclk)
    begin
        if (!aresetn || step_cnt_ff == 18'(STEP_CYC - 1))
            step_cnt_ff <= '0;
        else
            step_cnt_ff <= step_cnt_ff + 18'h1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            step_ff <= 1'b0;
        else
            step_ff <= (step_cnt_ff == 18'(STEP_CYC - 1));
    end

    ////////////////////////////////////////////////////////////////////////////
    // longitudinal current and low-pass filter

    assign long_sum = 18'(sense.q1) - 18'(sense.q6) - 18'(sense.q5) + 18'(sense.q2);

    always_ff @(posedge aclk)
    begin
        if (!aresetn || !open_state)
            long_cur_ff <= '0;
        else
            long_cur_ff <= long_sum[16:1];
    end

    // first-order step toward the input; 4000h reaches it in one step
    assign filt_delta = (34'(long_cur_ff) - 34'(filt_ff)) * $signed({18'h0, gk_coef_ff & COEF_MASK});

    always_ff @(posedge aclk)
    begin
        if (!aresetn || !open_state)
            filt_ff <= '0;
        else if (step_ff)
            filt_ff <= filt_ff + 16'(filt_delta >>> COEF_FRAC_BITS);
    end

    // magnitude compare: a grounded ring drives the current negative, a grounded tip drives it positive
    assign filt_mag = filt_ff[15] ? 17'(-(17'(filt_ff))) : 17'(filt_ff);
    assign loop_mag = loop_current[15] ? 17'(-(17'(loop_current))) : 17'(loop_current);

    always_ff @(posedge aclk)
    begin
        if (!aresetn || !open_state)
            gk_cmp_ff <= 1'b0;
        else if (!gk_cmp_ff && filt_mag > {1'b0, gk_en_th_ff})
            gk_cmp_ff <= 1'b1;
        else if (gk_cmp_ff && filt_mag < {1'b0, gk_rel_th_ff})
            gk_cmp_ff <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // debouncers: channel 0 ground key, channel 1 loop closure

    assign det_in[BIT_GK]     = gk_cmp_ff;
    assign det_in[BIT_LOOP]   = loop_mag > {1'b0, loop_offhk_ff};
    assign det_gate[BIT_GK]   = open_state;
    assign det_gate[BIT_LOOP] = 1'b1;
    assign det_ivl[BIT_GK]    = gk_dbi_ff;
    assign det_ivl[BIT_LOOP]  = loop_dbi_ff;

    for (genvar ch = 0; ch < NUM_DET; ch++)
    begin : g_deb
        // any return to agreement restarts the interval from zero
        always_ff @(posedge aclk)
        begin
            if (!aresetn || !det_gate[ch])
            begin
                det_cnt_ff[ch] <= '0;
                det_ff[ch]     <= 1'b0;
            end
            else if (det_in[ch] == det_ff[ch])
                det_cnt_ff[ch] <= '0;
            else if (det_ivl[ch] == '0 || (step_ff && 17'(det_cnt_ff[ch]) + 17'h1 >= 17'(det_ivl[ch])))
            begin
                det_cnt_ff[ch] <= '0;
                det_ff[ch]     <= det_in[ch];
            end
            else if (step_ff)
                det_cnt_ff[ch] <= det_cnt_ff[ch] + 16'h1;
        end

        always_ff @(posedge aclk)
        begin
            if (!aresetn)
                det_q_ff[ch] <= 1'b0;
            else
                det_q_ff[ch] <= det_ff[ch];
        end

        assign det_chg[ch] = det_ff[ch] != det_q_ff[ch];
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupts: change sets pending, write one clears, set wins

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq_vec_ff <= '0;
        else if (wr_go && waddr_ff == ADDR_IRQ_VEC_TWO && wstrb_ff[0])
            irq_vec_ff <= (irq_vec_ff & ~wdata_ff[NUM_DET-1:0]) | det_chg;
        else
            irq_vec_ff <= irq_vec_ff | det_chg;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq_ff <= 1'b0;
        else
            irq_ff <= |(irq_vec_ff & irq_en_ff);
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite read side

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= '0;
            rresp_ff   <= RESP_OKAY;
        end
        else if (arvalid && arready_ff)
        begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            rresp_ff   <= RESP_OKAY;
            case (araddr)
                ADDR_LINEFEED:     rdata_ff <= {29'h0, shadow_ff};
                ADDR_LOOP_RT_STAT: rdata_ff <= {30'h0, det_ff[BIT_LOOP], det_ff[BIT_GK]};
                ADDR_IRQ_VEC_TWO:  rdata_ff <= {30'h0, irq_vec_ff};
                ADDR_IRQ_EN_TWO:   rdata_ff <= {30'h0, irq_en_ff};
                ADDR_GK_DBI:       rdata_ff <= {16'h0, gk_dbi_ff};
                ADDR_LONG_CUR:     rdata_ff <= {16'h0, long_cur_ff};
                ADDR_GK_EN_TH:     rdata_ff <= {16'h0, gk_en_th_ff};
                ADDR_GK_REL_TH:    rdata_ff <= {16'h0, gk_rel_th_ff};
                ADDR_GK_COEF:      rdata_ff <= {16'h0, gk_coef_ff};
                ADDR_LOOP_OFFHK:   rdata_ff <= {16'h0, loop_offhk_ff};
                ADDR_LOOP_DBI:     rdata_ff <= {16'h0, loop_dbi_ff};
                default:
                begin
                    rdata_ff <= '0;
                    rresp_ff <= RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid_ff && rready)
        begin
            rvalid_ff  <= 1'b0;
            arready_ff <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign awready        = awready_ff;
    assign wready         = wready_ff;
    assign bvalid         = bvalid_ff;
    assign bresp          = bresp_ff;
    assign arready        = arready_ff;
    assign rvalid         = rvalid_ff;
    assign rdata          = rdata_ff;
    assign rresp          = rresp_ff;
    assign linefeed_state = shadow_ff;
    assign irq            = irq_ff;

endmodule

// *** bench/gkd_sva.sv ***
// checker: bus timing and linefeed move assertions of the ground key detector
`timescale 1ns/10ps
module gkd_sva
    import gkd_pkg::*;
(
    // clock and reset
    input wire logic              aclk,
    input wire logic              aresetn,
    // register bus
    input wire logic              awvalid,
    input wire logic              awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic              wvalid,
    input wire logic              wready,
    input wire logic              bvalid,
    input wire logic              bready,
    input wire logic [1:0]        bresp,
    input wire logic              arvalid,
    input wire logic              arready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic              rvalid,
    input wire logic              rready,
    input wire logic [31:0]       rdata,
    input wire logic [1:0]        rresp,
    // line side
    input wire logic [LF_W-1:0]   linefeed_state,
    input wire logic              irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_reset_idle: assert property (
        $rose(aresetn) |-> awready && arready && !bvalid && !rvalid && !irq && linefeed_state == 3'h0)
        else $error("outputs not idle after reset");
    a_write_answer: assert property (
        awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write response late");
    a_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read data late");
    a_bresp_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    a_rdata_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read data dropped");
    a_read_refused: assert property (rvalid |-> !arready)
        else $error("read accepted while busy");
    a_unmapped_wr: assert property (
        awvalid && awready && wvalid && wready && awaddr > ADDR_LOOP_DBI |-> ##2 bresp == RESP_SLVERR)
        else $error("unmapped write not refused");
    a_unmapped_rd: assert property (
        arvalid && arready && araddr > ADDR_LOOP_DBI |=> rresp == RESP_SLVERR && rdata == 32'h0)
        else $error("unmapped read not refused");
    // awready low marks a software write, which may set any code
    a_auto_move: assert property (
        awready && $changed(linefeed_state)
        && ($past(linefeed_state) == LF_TIP_OPEN || $past(linefeed_state) == LF_RING_OPEN)
        |-> linefeed_state == ($past(linefeed_state) == LF_TIP_OPEN ? LF_FWD_ACTIVE : LF_REV_ACTIVE))
        else $error("wrong automatic linefeed move");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind ground_key_detector gkd_sva i_gkd_sva
(
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .bvalid, .bready, .bresp,
    .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .linefeed_state, .irq
);

// *** bench/gkd_line_model.sv ***
// partner: terminal equipment on the line, drives transistor currents and grounds
`timescale 1ns/10ps
module gkd_line_model
    import gkd_pkg::*;
(
    // line condition: 0 open, 1 ring grounded, 2 tip grounded, 3 weak leak
    input  wire logic [1:0]    mode,
    // measurements toward the detector
    output sense_t             sense,
    output logic signed [15:0] loop_current,
    output ground_t            ground
);
    // leak sits between the two thresholds the bench programs
    always_comb
    begin
        sense        = '0;
        loop_current = 16'sh0000;
        ground       = '0;
        case (mode)
            2'h1:
            begin
                sense        = {16'h03E8, 16'h00C8, 16'h0BB8, 16'h0190};
                loop_current = 16'sh1000;
                ground       = 2'h1;
            end
            2'h2:
            begin
                sense        = {16'h0BB8, 16'h03E8, 16'h0190, 16'h00C8};
                loop_current = 16'sh1000;
                ground       = 2'h2;
            end
            2'h3:
                sense = {16'h0258, 16'h0000, 16'h0640, 16'h0000};
            default:
                sense = '0;
        endcase
    end
endmodule

// *** bench/tb_ground_key_detector.sv ***
// testbench: register map, detection, hysteresis, interrupt and linefeed move tests
`timescale 1ns/10ps
module tb_ground_key_detector
    import gkd_pkg::*;
;
    localparam int LIMIT = 5000;
    logic               aclk = 1'b0;
    logic               aresetn;
    logic               awvalid, wvalid, bready, arvalid, rready;
    logic               awready, wready, bvalid, arready, rvalid, irq;
    logic [7:0]         awaddr, araddr;
    logic [31:0]        wdata, rdata, rd_data;
    logic [3:0]         wstrb;
    logic [1:0]         bresp, rresp, wr_resp, rd_resp, mode;
    logic [2:0]         linefeed_state;
    logic signed [15:0] loop_current, longitudinal_current_sense;
    sense_t             sense;
    ground_t            ground;
    int                 error_cnt = 0;
    int                 cmp_count = 0;
    int                 cyc = 0;

    always #2.5 aclk = ~aclk;

    // short step keeps debounce waits to tens of cycles
    ground_key_detector #(.STEP_CYC(4)) i_ground_key_detector
    (
        .aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
        .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
        .sense, .loop_current, .ground, .linefeed_state, .irq
    );
    gkd_line_model i_gkd_line_model (.mode, .sense, .loop_current, .ground);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        awaddr  <= a;
        wdata   <= d;
        do
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while (awvalid || wvalid);
        while (!bvalid) @(posedge aclk);
        bready <= 1'b1;
        @(posedge aclk);
        wr_resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr  <= a;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge aclk);
        rready <= 1'b1;
        @(posedge aclk);
        rd_data = rdata;
        rd_resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        check(rd_data, exp);
    endtask

    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            error_cnt++;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        aresetn <= 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
        awaddr <= 8'h00;
        araddr <= 8'h00;
        wdata  <= 32'h0;
        wstrb  <= 4'hF;
        mode   <= 2'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(ADDR_GK_COEF, 32'h0A10);
        rchk(ADDR_IRQ_EN_TWO, 32'h0);
        wr(8'h2C, 32'h1);
        check({30'h0, wr_resp}, {30'h0, RESP_SLVERR});
        rd(8'h2C);
        check({30'h0, rd_resp}, {30'h0, RESP_SLVERR});
        $display("test reset_map done");
        wr(ADDR_LOOP_OFFHK, 32'h7FFF);
        wr(ADDR_GK_EN_TH, 32'h0320);
        wr(ADDR_GK_REL_TH, 32'h012C);
        wr(ADDR_GK_COEF, 32'h4007);
        rchk(ADDR_GK_COEF, 32'h4000);
        wr(ADDR_GK_DBI, 32'h5);
        wr(ADDR_IRQ_EN_TWO, 32'h1);
        mode <= 2'h1;
        idle(40);
        rchk(ADDR_LONG_CUR, 32'h0);
        rchk(ADDR_LOOP_RT_STAT, 32'h0);
        wr(ADDR_LINEFEED, {29'h0, LF_TIP_OPEN});
        longitudinal_current_sense = (sense.q1 - sense.q6 - sense.q5 + sense.q2) >>> 1;
        rd(ADDR_LONG_CUR);
        check({16'h0, rd_data[15:0]}, {16'h0, longitudinal_current_sense});
        rchk(ADDR_LOOP_RT_STAT, 32'h0);
        wr(ADDR_LONG_CUR, 32'h0);
        check({30'h0, wr_resp}, {30'h0, RESP_OKAY});
        rd(ADDR_LONG_CUR);
        check({16'h0, rd_data[15:0]}, {16'h0, longitudinal_current_sense});
        idle(40);
        rchk(ADDR_LOOP_RT_STAT, 32'h1);
        wr(ADDR_LOOP_RT_STAT, 32'h0);
        rchk(ADDR_LOOP_RT_STAT, 32'h1);
        rchk(ADDR_IRQ_VEC_TWO, 32'h1);
        check({31'h0, irq}, 32'h1);
        wr(ADDR_IRQ_VEC_TWO, 32'h1);
        rchk(ADDR_IRQ_VEC_TWO, 32'h0);
        check({31'h0, irq}, 32'h0);
        $display("test detect done");
        wr(ADDR_IRQ_EN_TWO, 32'h0);
        mode <= 2'h3;
        idle(40);
        rchk(ADDR_LOOP_RT_STAT, 32'h1);
        mode <= 2'h0;
        idle(40);
        rchk(ADDR_LOOP_RT_STAT, 32'h0);
        rchk(ADDR_IRQ_VEC_TWO, 32'h1);
        check({31'h0, irq}, 32'h0);
        mode <= 2'h3;
        idle(40);
        rchk(ADDR_LOOP_RT_STAT, 32'h0);
        wr(ADDR_GK_COEF, 32'h0);
        mode <= 2'h1;
        idle(40);
        rchk(ADDR_LOOP_RT_STAT, 32'h0);
        $display("test hysteresis done");
        wr(ADDR_GK_COEF, 32'h0A10);
        mode <= 2'h2;
        wr(ADDR_LOOP_OFFHK, 32'h0800);
        idle(12);
        rchk(ADDR_LINEFEED, {29'h0, LF_TIP_OPEN});
        mode <= 2'h0;
        idle(12);
        mode <= 2'h1;
        idle(12);
        rchk(ADDR_LINEFEED, {29'h0, LF_FWD_ACTIVE});
        check({29'h0, linefeed_state}, {29'h0, LF_FWD_ACTIVE});
        wr(ADDR_LINEFEED, {29'h0, LF_RING_OPEN});
        mode <= 2'h0;
        idle(12);
        mode <= 2'h2;
        idle(12);
        rchk(ADDR_LINEFEED, {29'h0, LF_REV_ACTIVE});
        check({29'h0, linefeed_state}, {29'h0, LF_REV_ACTIVE});
        rchk(ADDR_LOOP_RT_STAT, 32'h2);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(ADDR_LINEFEED, 32'h0);
        $display("test auto_move done");
        complete_run();
    end
endmodule
